// ===== period_measurement_counter.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns

// What this block does
// - Mode field code 110 selects period measurement; other codes halt the channel.
// - After a trigger, measure just the first full input cycle, low plus high.
// - Measurement starts on the low or the high portion, by polarity field.
// - Polarity field 01 starts on low, 10 on high, 00 and 11 disable.
// - External clock counts only with its polarity 01 or 10 and source 101.
// - Source codes 000 to 100 pick doubling internal rates; 000 after reset.
// - A write to the trigger register starts a measurement.
// - External trigger also starts; counting begins at next active portion.
// - Any accepted trigger clears the counter to zero first.
// - Counter adds one per selected clock tick; read back at any time.
// - Result is within one tick of the true period over the tick period.
// - A period beyond counter range reads back as all ones.
// - Each completed measurement drives a 1.75 us pulse on the output pin.
// - Output pin idles released high; bit 3 sets driven active level.
// - Debounce bit 13 rejects input and trigger pulses of 2.5 us or less.
// - Debounce may add up to 800 ns of measurement error.
// - Control bit 14 always reads as zero.
// - With bit 15 set, completion of the first full cycle raises pending.
// - With no external clock, measurement still completes with count zero.
// - Pending stays until software writes one to its status bit.
// - Writing control bit 15 low also clears pending.
module period_measurement_counter (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [period_meas_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [period_meas_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Field inputs
	input wire logic measured_input,
	input wire logic external_clock_input,
	input wire logic trigger_input,
	// Counter output pin, released while oe_n is high
	output logic counter_out,
	output logic counter_out_oe_n,
	// Pending interrupt
	output logic irq_pending
);
	import period_meas_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic pol_edge(input logic [1:0] pol, input logic prev, input logic cur);
		pol_edge = ((pol == POL_LOW) && prev && !cur) || ((pol == POL_HIGH) && !prev && cur);
	endfunction : pol_edge

	function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[7:2];
	endfunction : word_idx

	logic aw_have_r;
	logic w_have_r;
	logic ar_have_r;
	logic [5:0] aw_idx_r;
	logic [5:0] ar_idx_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic rd_go;
	logic [15:0] board_r;
	ctrl_t ctrl_r;
	ctrl_t ctrl_nxt;
	meas_state_t state_r;
	logic [15:0] count_r;
	logic [31:0] phase_r;
	logic [32:0] phase_sum;
	logic [2:0] rate_idx;
	logic meas_lvl;
	logic ext_lvl;
	logic trig_lvl;
	logic meas_prev_r;
	logic ext_prev_r;
	logic trig_prev_r;
	logic act_edge;
	logic mode_ok;
	logic int_sel;
	logic ext_sel;
	logic tick;
	logic trig_ok;
	logic done;
	logic irq_clear;
	logic pulse_on_r;
	logic [8:0] pulse_cnt_r;
	logic [8:0] pulse_len_r;

	// ------------------------------------------------------------
	// AXI4-Lite write channels
	// ------------------------------------------------------------
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_have_r <= 1'b0;
			aw_idx_r <= 6'h00;
		end else if (s_axi_awready && s_axi_awvalid) begin
			s_axi_awready <= 1'b0;
			aw_have_r <= 1'b1;
			aw_idx_r <= word_idx(s_axi_awaddr);
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
		end else if (!aw_have_r && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_have_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			s_axi_wready <= 1'b0;
			w_have_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_r <= 1'b0;
		end else if (!w_have_r && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_idx_r)
				IDX_BOARD, IDX_IRQ, IDX_TRIG, IDX_CTRL, IDX_COUNT: s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channels
	// ------------------------------------------------------------
	assign rd_go = ar_have_r && !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			ar_have_r <= 1'b0;
			ar_idx_r <= 6'h00;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			ar_have_r <= 1'b1;
			ar_idx_r <= word_idx(s_axi_araddr);
		end else if (rd_go) begin
			ar_have_r <= 1'b0;
		end else if (!ar_have_r && !s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			unique case (ar_idx_r)
				IDX_BOARD: s_axi_rdata[15:0] <= board_r;
				IDX_IRQ: s_axi_rdata[IRQ_BIT] <= irq_pending;
				IDX_TRIG: s_axi_rdata[15:0] <= 16'h0000;
				IDX_CTRL: s_axi_rdata[15:0] <= ctrl_r & CTRL_RMASK;
				IDX_COUNT: s_axi_rdata[15:0] <= count_r;
				default: s_axi_rresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Board and channel control registers
	// ------------------------------------------------------------
	assign ctrl_nxt = ctrl_t'(merge16(ctrl_r, wdata_r, wstrb_r));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			board_r <= BOARD_RESET;
		end else if (wr_go && aw_idx_r == IDX_BOARD) begin
			board_r <= merge16(board_r, wdata_r, wstrb_r) & 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= ctrl_t'(CTRL_RESET);
		end else if (wr_go && aw_idx_r == IDX_CTRL) begin
			ctrl_r <= ctrl_t'(ctrl_nxt & CTRL_RMASK);
		end
	end

	// ------------------------------------------------------------
	// Input conditioning and edges
	// ------------------------------------------------------------
	input_conditioner u_meas (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw(measured_input),
		.filter_en(ctrl_r.deb_en),
		.level(meas_lvl)
	);

	input_conditioner u_extclk (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw(external_clock_input),
		.filter_en(1'b0),
		.level(ext_lvl)
	);

	input_conditioner u_trig (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw(trigger_input),
		.filter_en(ctrl_r.deb_en),
		.level(trig_lvl)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_prev_r <= 1'b0;
			ext_prev_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			meas_prev_r <= meas_lvl;
			ext_prev_r <= ext_lvl;
			trig_prev_r <= trig_lvl;
		end
	end

	assign act_edge = pol_edge(ctrl_r.in_pol, meas_prev_r, meas_lvl);
	assign mode_ok = (ctrl_r.mode == MODE_PERIOD) &&
		((ctrl_r.in_pol == POL_LOW) || (ctrl_r.in_pol == POL_HIGH));
	assign trig_ok = mode_ok && ((wr_go && aw_idx_r == IDX_TRIG) ||
		pol_edge(ctrl_r.trig_pol, trig_prev_r, trig_lvl));
	assign done = (state_r == ST_MEASURE) && act_edge && !trig_ok;

	// ------------------------------------------------------------
	// Counting clock: internal phase accumulator or external edges
	// ------------------------------------------------------------
	assign int_sel = ctrl_r.clk_src <= CLK_INT_MAX;
	assign ext_sel = (ctrl_r.clk_src == CLK_EXT) &&
		((ctrl_r.ext_pol == POL_LOW) || (ctrl_r.ext_pol == POL_HIGH));
	assign rate_idx = ctrl_r.clk_src + (board_r[CARRIER_BIT] ? CARRIER32_SHIFT : 3'h0);
	assign phase_sum = {1'b0, phase_r} + {1'b0, BASE_STEP << rate_idx};
	assign tick = int_sel ? phase_sum[32] :
		(ext_sel && pol_edge(ctrl_r.ext_pol, ext_prev_r, ext_lvl));

	always_ff @(posedge aclk) begin
		if (!aresetn || !int_sel) begin
			phase_r <= 32'h0000_0000;
		end else begin
			phase_r <= phase_sum[31:0];
		end
	end

	// ------------------------------------------------------------
	// Measurement sequence
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
		end else if (!mode_ok) begin
			state_r <= ST_IDLE;
		end else if (trig_ok) begin
			state_r <= ST_ARMED;
		end else begin
			unique case (state_r)
				ST_IDLE: state_r <= ST_IDLE;
				ST_ARMED: state_r <= act_edge ? ST_MEASURE : ST_ARMED;
				ST_MEASURE: state_r <= act_edge ? ST_IDLE : ST_MEASURE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= 16'h0000;
		end else if (trig_ok) begin
			count_r <= 16'h0000;
		end else if (state_r == ST_MEASURE && !act_edge && tick && count_r != COUNT_MAX) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Completion pulse on the output pin
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_on_r <= 1'b0;
			pulse_cnt_r <= 9'h000;
		end else if (done) begin
			pulse_on_r <= 1'b1;
			pulse_cnt_r <= 9'(PULSE_CYC - 1);
		end else if (pulse_on_r) begin
			pulse_on_r <= pulse_cnt_r != 9'h000;
			pulse_cnt_r <= pulse_cnt_r - 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_out <= 1'b1;
			counter_out_oe_n <= 1'b1;
		end else begin
			counter_out <= pulse_on_r ? ctrl_r.out_pol : 1'b1;
			counter_out_oe_n <= !pulse_on_r;
		end
	end

	// ------------------------------------------------------------
	// Pending interrupt: set wins over clear
	// ------------------------------------------------------------
	assign irq_clear = wr_go && ((aw_idx_r == IDX_IRQ && wstrb_r[0] && wdata_r[IRQ_BIT]) ||
		(aw_idx_r == IDX_CTRL && !ctrl_nxt.irq_en));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pending <= 1'b0;
		end else if (done && ctrl_r.irq_en) begin
			irq_pending <= 1'b1;
		end else if (irq_clear) begin
			irq_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || done || !pulse_on_r) begin
			pulse_len_r <= 9'h000;
		end else begin
			pulse_len_r <= pulse_len_r + 9'h001;
		end
	end

	property p_mode_gate;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl_r.mode != MODE_PERIOD) |=> (state_r == ST_IDLE);
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("channel ran outside period mode");

	property p_trig_clears;
		@(posedge aclk) disable iff (!aresetn)
		trig_ok |=> (count_r == 16'h0000) && (state_r == ST_ARMED);
	endproperty
	a_trig_clears: assert property (p_trig_clears) else $error("trigger did not clear count");

	property p_count_step;
		@(posedge aclk) disable iff (!aresetn)
		(state_r == ST_MEASURE && tick && !act_edge && !trig_ok && count_r != COUNT_MAX)
			|=> (count_r == $past(count_r) + 16'h0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter missed a tick");

	property p_saturate;
		@(posedge aclk) disable iff (!aresetn)
		(count_r == COUNT_MAX && !trig_ok) |=> (count_r == COUNT_MAX);
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter wrapped");

	property p_no_clock;
		@(posedge aclk) disable iff (!aresetn)
		(!int_sel && !ext_sel) |-> !tick;
	endproperty
	a_no_clock: assert property (p_no_clock) else $error("tick without a valid source");

	property p_pulse_len;
		@(posedge aclk) disable iff (!aresetn)
		$fell(pulse_on_r) |-> (pulse_len_r == PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("output pulse length wrong");

	property p_pin_drive;
		@(posedge aclk) disable iff (!aresetn)
		done |=> ##1 (!counter_out_oe_n && counter_out == $past(ctrl_r.out_pol));
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin not driven after completion");

	property p_irq_set;
		@(posedge aclk) disable iff (!aresetn)
		(done && ctrl_r.irq_en) |=> irq_pending;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("completion did not set pending");

	property p_irq_hold;
		@(posedge aclk) disable iff (!aresetn)
		(irq_pending && !irq_clear) |=> irq_pending;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("pending dropped without clear");

	property p_ie_clear;
		@(posedge aclk) disable iff (!aresetn)
		(wr_go && aw_idx_r == IDX_CTRL && !ctrl_nxt.irq_en && !done) |=> !irq_pending;
	endproperty
	a_ie_clear: assert property (p_ie_clear) else $error("enable low did not clear");

	property p_bit14;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && ar_idx_r == IDX_CTRL) |-> !s_axi_rdata[14];
	endproperty
	a_bit14: assert property (p_bit14) else $error("unused control bit read as one");

endmodule : period_measurement_counter

// ===== period_meas_pkg.sv
package period_meas_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_HZ = 125_000_000;
	localparam int PULSE_NS = 1750;
	localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_NS = 2500;
	localparam int DEB_CYC = DEB_NS / CLK_PERIOD_NS + 1;
	localparam int MEAS_ERR_DEB_NS = 800;
	localparam int BASE_RATE_HZ = 500_000;
	localparam logic [31:0] BASE_STEP = 32'((64'(BASE_RATE_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [2:0] CARRIER32_SHIFT = 3'h2;

	// ------------------------------------------------------------
	// Register map (word index, byte address is four times it)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_BOARD = 6'h00;
	localparam logic [5:0] IDX_IRQ = 6'h02;
	localparam logic [5:0] IDX_TRIG = 6'h04;
	localparam logic [5:0] IDX_CTRL = 6'h06;
	localparam logic [5:0] IDX_COUNT = 6'h08;
	localparam int CARRIER_BIT = 0;
	localparam int IRQ_BIT = 0;
	localparam logic [15:0] BOARD_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RMASK = 16'hBFFF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Channel control fields and codes
	// ------------------------------------------------------------
	typedef struct packed {
		logic irq_en;
		logic unused;
		logic deb_en;
		logic [2:0] clk_src;
		logic [1:0] trig_pol;
		logic [1:0] ext_pol;
		logic [1:0] in_pol;
		logic out_pol;
		logic [2:0] mode;
	} ctrl_t;

	localparam logic [2:0] MODE_PERIOD = 3'h6;
	localparam logic [1:0] POL_LOW = 2'h1;
	localparam logic [1:0] POL_HIGH = 2'h2;
	localparam logic [2:0] CLK_INT_MAX = 3'h4;
	localparam logic [2:0] CLK_EXT = 3'h5;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_MEASURE = 2'h3
	} meas_state_t;

endpackage : period_meas_pkg

// ===== input_conditioner.sv
`timescale 1ns/1ns

module input_conditioner
	import period_meas_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin and filter control
	input wire logic raw,
	input wire logic filter_en,
	// Conditioned level
	output logic level
);

	logic sync1_r;
	logic sync2_r;
	logic [8:0] stable_r;

	// ------------------------------------------------------------
	// Synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
		end
	end

	// ------------------------------------------------------------
	// Debounce: new level accepted once it outlasts the reject window
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stable_r <= 9'h000;
			level <= 1'b0;
		end else if (!filter_en) begin
			stable_r <= 9'h000;
			level <= sync2_r;
		end else if (sync2_r == level) begin
			stable_r <= 9'h000;
		end else if (stable_r == 9'(DEB_CYC - 1)) begin
			stable_r <= 9'h000;
			level <= sync2_r;
		end else begin
			stable_r <= stable_r + 9'h001;
		end
	end

endmodule : input_conditioner

// ===== signal_source_model.sv
`timescale 1ns/1ns

module signal_source_model (
	// Clock
	input wire logic aclk,
	// Waveform shape in clock cycles
	input wire logic [15:0] low_cyc,
	input wire logic [15:0] high_cyc,
	input wire logic [15:0] ext_half,
	// Field signals
	output logic measured_input,
	output logic external_clock_input,
	output logic trigger_input
);
	logic [15:0] wave_cnt = 16'h0000;
	logic [15:0] ext_cnt = 16'h0000;

	initial begin
		measured_input = 1'b0;
		external_clock_input = 1'b0;
		trigger_input = 1'b0;
	end

	// ----
	// Repeating waveform and count clock
	// ----
	always @(posedge aclk) begin
		if (wave_cnt + 16'h0001 >= (measured_input ? high_cyc : low_cyc)) begin
			measured_input <= ~measured_input;
			wave_cnt <= 16'h0000;
		end else begin
			wave_cnt <= wave_cnt + 16'h0001;
		end
	end

	// Clock stands still while no half period is set
	always @(posedge aclk) begin
		if (ext_half == 16'h0000) begin
			ext_cnt <= 16'h0000;
		end else if (ext_cnt + 16'h0001 >= ext_half) begin
			external_clock_input <= ~external_clock_input;
			ext_cnt <= 16'h0000;
		end else begin
			ext_cnt <= ext_cnt + 16'h0001;
		end
	end

	task automatic fire(input int len);
		trigger_input <= 1'b1;
		repeat (len) @(posedge aclk);
		trigger_input <= 1'b0;
	endtask : fire
endmodule : signal_source_model

// ===== period_measurement_counter_tb.sv
`timescale 1ns/1ns

module period_measurement_counter_tb;
	import period_meas_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic measured_input, external_clock_input, trigger_input;
	logic counter_out, counter_out_oe_n, irq_pending;
	logic [15:0] low_cyc = 16'h0190, high_cyc = 16'h0190, ext_half = 16'h0000;
	logic [31:0] r;
	logic [2:0] code;
	int bad_count = 0, n_checks = 0, seed = 65246;
	bit alt = 1'b0;

	always #4 aclk = ~aclk;

	period_measurement_counter i_period_measurement_counter (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .measured_input, .external_clock_input,
		.trigger_input, .counter_out, .counter_out_oe_n, .irq_pending);

	signal_source_model i_signal_source_model (.aclk, .low_cyc, .high_cyc, .ext_half,
		.measured_input, .external_clock_input, .trigger_input);

	// ----
	// Checking and bus tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	function automatic int expect_count(int per, logic [2:0] cd, bit b);
		return int'(((longint'(per) * BASE_RATE_HZ) << (cd + (b ? 2 : 0))) / CLK_HZ);
	endfunction : expect_count

	function automatic logic near(logic [15:0] s, int e, int t);
		return (s + t >= e) && (s <= e + t);
	endfunction : near

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
		end while ((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rd_reg

	task automatic meas(input logic [15:0] c, input int e, input int tol, input int tl);
		int n;
		bit got;
		wr(8'h18, {16'h0000, c});
		if (tl > 0) begin
			i_signal_source_model.fire(tl);
		end else begin
			wr(8'h10, 32'h0000_0000);
		end
		n = 0;
		while (counter_out_oe_n !== 1'b0 && n < 3 * (low_cyc + high_cyc) + 1600) begin
			@(posedge aclk);
			n++;
		end
		got = counter_out_oe_n === 1'b0;
		check(got, e >= 0);
		if (got) begin
			check(counter_out, c[3]);
			n = 0;
			while (counter_out_oe_n === 1'b0) begin
				n++;
				@(posedge aclk);
			end
			check(n, PULSE_CYC);
			check(counter_out, 1'b1);
			check(irq_pending, c[15]);
			rd_reg(8'h20);
			check(near(rd[15:0], e, tol), 1'b1);
			check(irq_pending, c[15]);
			alt = ~alt;
			if (alt) begin
				wr(8'h08, 32'h0000_0001);
			end else begin
				wr(8'h18, {16'h0000, c & 16'h7fff});
			end
			check(irq_pending, 1'b0);
		end
	endtask : meas

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(counter_out_oe_n, 1'b1);
		check(irq_pending, 1'b0);
		rd_reg(8'h18);
		check(rd, {16'h0000, CTRL_RESET});
		wr(8'h18, 32'h0000_ffff);
		rd_reg(8'h18);
		check(rd, {16'h0000, CTRL_RMASK});
		wr(8'h00, 32'h0000_ffff);
		rd_reg(8'h00);
		check(rd, 32'h0000_0001);
		rd_reg(8'h10);
		check(rd, 32'h0000_0000);
		wr(8'h3c, 32'h0000_0001);
		check(rsp, RESP_SLVERR);
		rd_reg(8'h3c);
		check(rsp, RESP_SLVERR);
		wr(8'h18, 32'h0000_0000);
		repeat (6) begin
			r = $random(seed);
			code = 3'(r[15:8] % 8'h05);
			low_cyc <= 16'h0190 + 16'($unsigned($random(seed)) % 800);
			high_cyc <= 16'h0190 + 16'($unsigned($random(seed)) % 800);
			wr(8'h00, {31'h0000_0000, r[3]});
			meas({r[0], 2'b00, code, 4'h0, r[1] ? POL_HIGH : POL_LOW, r[2], MODE_PERIOD},
				expect_count(low_cyc + high_cyc, code, r[3]), 1, 0);
		end
		wr(8'h00, 32'h0000_0000);
		low_cyc <= 16'h0320;
		high_cyc <= 16'h0320;
		ext_half <= 16'h000a;
		for (int ep = 0; ep < 4; ep++) begin
			meas({1'b1, 2'b00, CLK_EXT, 2'b10, 2'(ep), POL_HIGH, 1'b0, MODE_PERIOD},
				(ep == 1 || ep == 2) ? 80 : 0, 1, 20);
		end
		ext_half <= 16'h0000;
		meas({1'b1, 2'b00, CLK_EXT, 2'b01, 2'b10, POL_LOW, 1'b1, MODE_PERIOD}, 0, 0, 20);
		meas(16'h2226, -1, 0, 200);
		meas(16'h2226, expect_count(low_cyc + high_cyc, 3'h0, 1'b0), 2, 400);
		low_cyc <= 16'h00c8;
		high_cyc <= 16'h00c8;
		for (int i = 0; i < 3; i++) begin
			meas(i == 0 ? 16'h0025 : (i == 1 ? 16'h0006 : 16'h0036), -1, 0, 0);
		end
		give_verdict();
	end

	initial begin
		#760_000;
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule : period_measurement_counter_tb
